// [hw/byte_store_defines.svh]
// constants for the byte store access unit
`ifndef BYTE_STORE_DEFINES_SVH
`define BYTE_STORE_DEFINES_SVH
`define BS_DEPTH       56832
`define BS_LAST_ADDR   16'hddff
`define BS_ADDR_W      16
`define BS_MAX_LEN     3'h4
`define BS_CLK_MHZ     125
`define BS_WRITE_NS    20000
`define BS_WRITE_CYC   ((`BS_WRITE_NS * `BS_CLK_MHZ) / 1000)
`define BS_CNT_W       12
`endif

// [hw/byte_store_pkg.sv]
// types shared by the byte store access unit
package byte_store_pkg;
    typedef enum logic [2:0] {
        OP_MREAD  = 3'h0,
        OP_MWRITE = 3'h1,
        OP_BREAD  = 3'h2,
        OP_BWRITE = 3'h3,
        OP_CLEAR  = 3'h4
    } op_e;
    typedef logic [15:0] addr_t;
endpackage : byte_store_pkg

// [hw/byte_store_ram.sv]
// single-port byte-wide storage array
`timescale 1ns/10ps
`default_nettype none
`include "byte_store_defines.svh"
module byte_store_ram (
    // clock
    input  wire logic                       i_clk,
    // access
    input  wire logic                       i_we,
    input  wire byte_store_pkg::addr_t      i_addr,
    input  wire logic [7:0]                 i_wdata,
    output logic      [7:0]                 o_rdata
);
    import byte_store_pkg::*;
    // no reset: contents survive like battery-backed memory
    logic [7:0] mem [0:`BS_DEPTH-1];
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule : byte_store_ram
`default_nettype wire

// [hw/byte_store_access_unit.sv]
// command-driven access unit for the byte store
`timescale 1ns/10ps
`default_nettype none
`include "byte_store_defines.svh"
module byte_store_access_unit (
    // clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_arst_n,
    // command
    input  wire logic                       i_cmd_valid,
    output logic                            o_cmd_ready,
    input  wire byte_store_pkg::op_e        i_cmd_op,
    input  wire byte_store_pkg::addr_t      i_cmd_addr,
    input  wire logic [2:0]                 i_cmd_len,
    input  wire logic [31:0]                i_cmd_wdata,
    // answer
    output logic                            o_done,
    output logic                            o_err,
    output logic [31:0]                     o_rdata
);
    import byte_store_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_READ  = 5'h02,
        ST_WRITE = 5'h04,
        ST_CLEAR = 5'h08,
        ST_HOLD  = 5'h10
    } state_e;

    typedef struct packed {
        state_e                 st;
        addr_t                  addr;
        logic [2:0]             len;
        logic [2:0]             idx;
        logic                   rd_pend;
        logic [31:0]            wdata;
        logic [31:0]            rdata;
        logic [`BS_CNT_W-1:0]   cnt;
        logic                   done;
        logic                   err;
        logic                   sync_meta;
        logic                   sync_ok;
    } state_s;

    localparam logic [`BS_CNT_W-1:0] WRITE_CYC = `BS_CNT_W'(`BS_WRITE_CYC);

    state_s     s_r;
    state_s     s_nxt;
    logic       ram_we;
    addr_t      ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;

    // range check of a span; widened to avoid wrap past 16 bits
    function automatic logic span_ok(input addr_t a, input logic [2:0] n);
        logic [16:0] last;
        last = {1'b0, a} + {14'h0, n} - 17'h1;
        return (n != 3'h0) && (last <= {1'b0, `BS_LAST_ADDR});
    endfunction : span_ok

    // address of the byte at offset k from the start of the access
    function automatic addr_t byte_addr(input addr_t a, input logic [2:0] k);
        return a + addr_t'(k);
    endfunction : byte_addr

    // true once every byte of the access has been moved
    function automatic logic all_moved(input logic [2:0] idx, input logic [2:0] len);
        return idx == len;
    endfunction : all_moved

    // byte lane k of a value, lowest lane first; k stays below 4
    function automatic logic [7:0] lane(input logic [31:0] v, input logic [2:0] k);
        return v[8*k +: 8];
    endfunction : lane

    // byte count implied by the op; zero marks an unusable op, except for OP_CLEAR
    function automatic logic [2:0] op_len(input op_e op, input logic [2:0] n);
        logic [2:0] len;
        case (op)
            OP_MREAD, OP_MWRITE: begin
                len = n;
            end
            OP_BREAD, OP_BWRITE: begin
                len = 3'h1;
            end
            default: begin
                len = 3'h0;
            end
        endcase
        return len;
    endfunction : op_len

    // unknown op, bad length or span past the last byte
    function automatic logic refused(input op_e op, input addr_t a, input logic [2:0] n);
        return (op != OP_CLEAR) && (!span_ok(a, n) || n > `BS_MAX_LEN);
    endfunction : refused

    always_comb begin
        s_nxt     = s_r;
        s_nxt.done = 1'b0;
        ram_we    = 1'b0;
        ram_addr  = byte_addr(s_r.addr, s_r.idx);
        ram_wdata = lane(s_r.wdata, 3'h0);
        // reset release is asynchronous: two stages before any command is taken
        s_nxt.sync_meta = 1'b1;
        s_nxt.sync_ok   = s_r.sync_meta;
        case (s_r.st)
            ST_IDLE: begin
                if (i_cmd_valid && s_r.sync_ok) begin
                    s_nxt.addr    = i_cmd_addr;
                    s_nxt.wdata   = i_cmd_wdata;
                    s_nxt.idx     = 3'h0;
                    s_nxt.rdata   = 32'h0;
                    s_nxt.rd_pend = 1'b0;
                    s_nxt.cnt     = '0;
                    s_nxt.err     = 1'b0;
                    s_nxt.len = op_len(i_cmd_op, i_cmd_len);
                    case (i_cmd_op)
                        OP_MREAD, OP_BREAD: begin
                            s_nxt.st = ST_READ;
                        end
                        OP_MWRITE, OP_BWRITE: begin
                            s_nxt.st = ST_WRITE;
                        end
                        OP_CLEAR: begin
                            s_nxt.addr = 16'h0;
                            s_nxt.st   = ST_CLEAR;
                        end
                        default: begin
                            s_nxt.err  = 1'b1;
                            s_nxt.done = 1'b1;
                        end
                    endcase
                    // out-of-range or bad length: refused, store untouched
                    if (refused(i_cmd_op, i_cmd_addr, s_nxt.len)) begin
                        s_nxt.st   = ST_IDLE;
                        s_nxt.err  = 1'b1;
                        s_nxt.done = 1'b1;
                    end
                end
            end
            ST_READ: begin
                // ram answers one cycle late; place byte by its offset
                if (s_r.rd_pend) begin
                    s_nxt.rdata[8*(s_r.idx-3'h1) +: 8] = ram_rdata;
                end
                ram_addr = byte_addr(s_r.addr, s_r.idx);
                if (all_moved(s_r.idx, s_r.len)) begin
                    s_nxt.st   = ST_IDLE;
                    s_nxt.done = 1'b1;
                    s_nxt.rd_pend = 1'b0;
                end else begin
                    s_nxt.rd_pend = 1'b1;
                    s_nxt.idx     = s_r.idx + 3'h1;
                end
            end
            ST_WRITE: begin
                if (!all_moved(s_r.idx, s_r.len)) begin
                    ram_we    = 1'b1;
                    ram_wdata = lane(s_r.wdata, s_r.idx);
                    s_nxt.idx = s_r.idx + 3'h1;
                end
                s_nxt.cnt = s_r.cnt + `BS_CNT_W'(1);
                // multi-byte writes are paced to a fixed completion time
                if (all_moved(s_r.idx, s_r.len) &&
                    (s_r.len == 3'h1 || s_r.cnt >= WRITE_CYC - `BS_CNT_W'(1))) begin
                    s_nxt.st   = ST_IDLE;
                    s_nxt.done = 1'b1;
                end
            end
            ST_CLEAR: begin
                ram_we    = 1'b1;
                ram_addr  = s_r.addr;
                ram_wdata = 8'h00;
                s_nxt.addr = s_r.addr + 16'h1;
                if (s_r.addr == `BS_LAST_ADDR) begin
                    s_nxt.st   = ST_IDLE;
                    s_nxt.done = 1'b1;
                end
            end
            default: begin
                // illegal state code: recover to idle, keep the reset stages
                s_nxt.st      = ST_IDLE;
                s_nxt.idx     = 3'h0;
                s_nxt.rd_pend = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_r <= '{st: ST_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    byte_store_ram u_ram (
        .i_clk   (i_clk),
        .i_we    (ram_we),
        .i_addr  (ram_addr),
        .i_wdata (ram_wdata),
        .o_rdata (ram_rdata)
    );

    // handshake from state; data outputs straight from flip-flops
    assign o_cmd_ready = (s_r.st == ST_IDLE) && s_r.sync_ok;
    assign o_done      = s_r.done;
    assign o_err       = s_r.err;
    assign o_rdata     = s_r.rdata;
endmodule : byte_store_access_unit
`default_nettype wire

// [tb/byte_store_access_unit_sva.sv]
// port checks for the byte store access unit
`timescale 1ns/10ps
`default_nettype none
module byte_store_access_unit_sva (
    input wire logic                  i_clk,
    input wire logic                  i_arst_n,
    input wire logic                  i_cmd_valid,
    input wire logic                  o_cmd_ready,
    input wire byte_store_pkg::op_e   i_cmd_op,
    input wire byte_store_pkg::addr_t i_cmd_addr,
    input wire logic [2:0]            i_cmd_len,
    input wire logic [31:0]           i_cmd_wdata,
    input wire logic                  o_done,
    input wire logic                  o_err,
    input wire logic [31:0]           o_rdata
);
    import byte_store_pkg::*;
    logic tk;
    logic mop;
    logic fit;
    assign tk = i_cmd_valid && o_cmd_ready;
    assign mop = tk && i_cmd_op inside {OP_MREAD, OP_MWRITE};
    assign fit = {1'b0, i_cmd_addr} + {14'h0, i_cmd_len} <= 17'h0de00;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence rd1;
        !o_done ##1 !o_done ##1 o_done && !o_err && o_rdata[31:8] == 24'h0;
    endsequence
    sequence rd4;
        !o_done [*5] ##1 o_done && !o_err;
    endsequence
    byte_read_a: assert property (tk && i_cmd_op == OP_BREAD && i_cmd_addr <= 16'hddff |=> rd1)
        else $error("byte read");
    quad_read_a: assert property (mop && i_cmd_op == OP_MREAD && i_cmd_len == 3'h4 && fit |=> rd4)
        else $error("quad read");
    part_read_a: assert property (mop && i_cmd_op == OP_MREAD && i_cmd_len == 3'h2 && fit
        |=> !o_done [*3] ##1 o_done && o_rdata[31:16] == 16'h0) else $error("part read");
    span_err_a: assert property (mop && !fit |=> o_done && o_err) else $error("span");
    len_err_a: assert property (mop && (i_cmd_len == 3'h0 || i_cmd_len > 3'h4) |=> o_done && o_err)
        else $error("length");
    byte_write_a: assert property (tk && i_cmd_op == OP_BWRITE && i_cmd_addr <= 16'hddff
        |=> !o_done ##1 !o_done ##1 o_done && !o_err) else $error("byte write");
    write_pace_a: assert property (mop && i_cmd_op == OP_MWRITE && i_cmd_len inside {[2:4]} && fit
        |=> !o_done [*8] ##292 !o_cmd_ready) else $error("write pace");
    clear_busy_a: assert property (tk && i_cmd_op == OP_CLEAR |=> !o_cmd_ready [*8] ##292 !o_done)
        else $error("clear");
    // cycles since a paced multi-byte write was taken; too long for a repetition
    logic        wr_busy;
    logic [11:0] wr_cnt;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_busy <= 1'b0;
            wr_cnt  <= 12'h0;
        end else if (mop && i_cmd_op == OP_MWRITE && i_cmd_len inside {[2:4]} && fit) begin
            wr_busy <= 1'b1;
            wr_cnt  <= 12'h0;
        end else if (o_done) begin
            wr_busy <= 1'b0;
        end else if (wr_busy) begin
            wr_cnt <= wr_cnt + 12'h1;
        end
    end
    write_time_a: assert property (wr_busy && o_done |-> wr_cnt == 12'h9c4)
        else $error("write done early");
    write_late_a: assert property (wr_busy |-> wr_cnt <= 12'h9c4)
        else $error("write done late");
endmodule : byte_store_access_unit_sva
bind byte_store_access_unit byte_store_access_unit_sva i_sva (.i_clk, .i_arst_n, .i_cmd_valid, .o_cmd_ready,
    .i_cmd_op, .i_cmd_addr, .i_cmd_len, .i_cmd_wdata, .o_done, .o_err, .o_rdata);
`default_nettype wire

// [tb/cmd_engine_model.sv]
// command engine model presenting requests to the access unit
`timescale 1ns/10ps
`default_nettype none
module cmd_engine_model (
    input  wire logic                 i_clk,
    input  wire logic                 i_ready,
    output var  logic                 o_valid,
    output var  byte_store_pkg::op_e  o_op,
    output var  byte_store_pkg::addr_t o_addr,
    output var  logic [2:0]           o_len,
    output var  logic [31:0]          o_wdata
);
    import byte_store_pkg::*;
    initial begin
        {o_valid, o_addr, o_len, o_wdata} = '0;
        o_op = OP_MREAD;
    end
    // integer data only; released address and data lines show inverted junk
    task automatic issue(input op_e op, input addr_t a, input logic [2:0] n, input logic [31:0] d);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_op <= op;
        o_addr <= a;
        o_len <= n;
        o_wdata <= d;
        do @(negedge i_clk); while (i_ready !== 1'b1);
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : issue
endmodule : cmd_engine_model
`default_nettype wire

// [tb/byte_store_access_unit_tb.sv]
// self-checking bench for the byte store access unit
`timescale 1ns/10ps
`default_nettype none
module byte_store_access_unit_tb;
    import byte_store_pkg::*;
    logic i_clk = 0, i_arst_n = 0, i_cmd_valid, o_cmd_ready, o_done, o_err;
    op_e i_cmd_op;
    addr_t i_cmd_addr, a;
    logic [2:0] i_cmd_len;
    logic [31:0] i_cmd_wdata, o_rdata, d;
    logic [32:0] notes[$];
    logic [7:0] mem[int];
    int seed = 30845, miscompares = 0, tests_run = 0, n;
    always #4 i_clk = ~i_clk;
    byte_store_access_unit i_dut (.i_clk, .i_arst_n, .i_cmd_valid, .o_cmd_ready, .i_cmd_op, .i_cmd_addr,
        .i_cmd_len, .i_cmd_wdata, .o_done, .o_err, .o_rdata);
    cmd_engine_model i_eng (.i_clk, .i_ready(o_cmd_ready), .o_valid(i_cmd_valid), .o_op(i_cmd_op),
        .o_addr(i_cmd_addr), .o_len(i_cmd_len), .o_wdata(i_cmd_wdata));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic run(input op_e op, input addr_t p, input logic [2:0] k, input logic [31:0] v);
        logic [32:0] e;
        int c;
        e = 33'h0;
        c = (op == OP_MREAD || op == OP_MWRITE) ? int'(k) : 1;
        if (op > OP_CLEAR || c == 0 || c > 4 || (op != OP_CLEAR && p + c > 56832)) e[32] = 1'b1;
        else if (op == OP_CLEAR) mem.delete();
        else for (int i = 0; i < c; i++)
            if (op == OP_MWRITE || op == OP_BWRITE) mem[p + i] = v[8*i +: 8];
            else e[8*i +: 8] = mem.exists(p + i) ? mem[p + i] : 8'h00;
        notes.push_back(e);
        i_eng.issue(op, p, k, v);
    endtask : run
    task automatic done_test(input string s);
        for (int w = 0; w < 60000 && notes.size() > 0; w++) @(posedge i_clk);
        $display("test %s over", s);
    endtask : done_test
    task give_verdict;
        if (notes.size() != 0) miscompares++;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge i_clk) if (o_done === 1'b1) begin
        if (notes.size() == 0) check(33'h1, 33'h0);
        else check({o_err, o_rdata}, notes.pop_front());
    end
    initial begin
        #720000;
        miscompares++;
        give_verdict;
    end
    initial begin
        repeat (8) @(posedge i_clk);
        i_arst_n <= 1'b1;
        run(OP_CLEAR, 0, 0, 0);
        run(OP_MREAD, 16'hddfc, 4, 0);
        done_test("clear");
        for (n = 1; n < 5; n++) begin
            d = $random(seed);
            a = 16'($unsigned($random(seed)) % 56000);
            run(OP_MWRITE, a, 3'(n), d);
            run(OP_MREAD, a, 3'(n), 0);
            run(OP_MREAD, a, 4, 0);
        end
        done_test("words");
        run(OP_MWRITE, 0, 2, 32'habcd);
        run(OP_MWRITE, 1, 2, 32'h6532);
        run(OP_MREAD, 0, 3, 0);
        run(OP_BWRITE, 16'hddff, 0, d);
        run(OP_BREAD, 16'hddff, 0, 0);
        run(OP_MREAD, 16'hddfe, 2, 0);
        done_test("bytes");
        run(op_e'(3'h5), 0, 1, 0);
        run(op_e'(3'h7), 0, 1, 0);
        run(OP_MREAD, 0, 0, 0);
        run(OP_MREAD, 0, 5, 0);
        run(OP_MWRITE, 16'hddfe, 4, d);
        run(OP_MREAD, 2, 2, 0);
        done_test("refusals");
        give_verdict;
    end
endmodule : byte_store_access_unit_tb
`default_nettype wire
